/* hdl/sbcmc_pkg.sv */
`default_nettype none
package sbcmc_pkg;
   // operating modes
   typedef enum logic [2:0] {
      MODE_OFF,
      MODE_RESET,
      MODE_STANDBY,
      MODE_NORMAL,
      MODE_FORCED,
      MODE_OVERTEMP
   } sbcmc_mode_e;

   // register indices
   localparam logic [7:0] ADDR_MODE   = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h03;
   localparam logic [7:0] ADDR_WDOG   = 8'h20;
   localparam logic [7:0] ADDR_CFG    = 8'h21;

   // mode select codes
   localparam logic [2:0] MSEL_STANDBY = 3'h4;
   localparam logic [2:0] MSEL_NORMAL  = 3'h7;

   // watchdog mode codes
   localparam logic [1:0] WD_OFF     = 2'h0;
   localparam logic [1:0] WD_WINDOW  = 2'h1;
   localparam logic [1:0] WD_TIMEOUT = 2'h2;

   // timing
   localparam int CLK_HZ           = 50000000;
   localparam int RESET_HOLD_US    = 20;
   localparam int RESET_HOLD_CYC   = (RESET_HOLD_US * (CLK_HZ / 1000000));
   localparam int SILENCE_US       = 50;
   localparam int SILENCE_CYC      = (SILENCE_US * (CLK_HZ / 1000000));
   localparam int WD_MIN_MS        = 8;
   localparam int WD_MIN_CYC       = WD_MIN_MS * (CLK_HZ / 1000);
   localparam int WD_MAX_MS        = 4000;
   localparam int WD_CODE_MAX      = 9;
   localparam int UV_CODE_W        = 2;

   // serial frame sizes
   localparam int SPI_BITS_16 = 16;
   localparam int SPI_BITS_24 = 24;
   localparam int SPI_BITS_32 = 32;

   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sbcmc_req_s;
endpackage
`default_nettype wire

/* hdl/sbcmc_top.sv */
// Notes on behaviour
// - six modes: normal, standby, reset, forced normal, overtemp, off
// - code 111 in standby moves to normal
// - code 100 in normal moves to standby
// - transceiver cannot send or receive in standby
// - standby keeps serial and regulator on, watchdog timeout if enabled
// - normal runs watchdog in window or timeout as programmed
// - normal keeps regulator on and allows active transceiver
// - with bus wake enable set, standby watches bus for wake-up
// - silence beyond timeout biases pins to ground, activity in standby with bus wake enable to mid level
// - receive output driven low on any enabled wake-up event
// - power-on leaves off through reset into standby, or forced normal with boot bit set
// - cooling leaves overtemp through reset into standby, or forced normal with boot bit set
// - watchdog period selectable from 8 ms up to 4 s
// - serial transfers of 16, 24 or 32 bits accepted
// - undervoltage threshold selectable 60, 70, 80 or 90 percent
// - captured wake-up re-enables the watchdog
// - timeout watchdog may raise cyclic wake-ups when configured
// - mode select field sits in bits 2:0 at address 01
// - reset mode ends in standby, or forced normal with boot bit set, once reset line released high
// - reset mode holds reset line low for the reset hold count only, serial off, watchdog off
`timescale 1ns/1ps
`default_nettype none
module sbcmc_top (
   input  wire logic       MCLK,
   input  wire logic       RST_B,
   input  wire logic       BAT_OK,
   input  wire logic       OVERTEMP,
   input  wire logic       BUS_ACTIVE,
   input  wire logic       RESET_LINE_N_IN,
   input  wire logic       FORCED_ACTIVE_BOOT_BIT,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   output logic            RESET_LINE_N_OUT,
   output logic            RESET_LINE_N_OE,
   output logic            REGULATOR_OUTPUT_EN,
   output logic            SERIAL_EN,
   output logic            CAN_ACTIVE,
   output logic            BIAS_MID,
   output logic            RXD_LOW,
   output logic      [1:0] WDOG_MODE,
   output logic      [3:0] WDOG_PERIOD,
   output logic      [1:0] UV_THRESHOLD
);
   sbcmc_pkg::sbcmc_mode_e mode_q;
   sbcmc_pkg::sbcmc_req_s  req;
   logic       bat_s1_q, bat_q, ot_s1_q, ot_q, bus_s1_q, bus_q;
   logic       rln_s1_q, rln_q, boot_s1_q, boot_q;
   logic [2:0] msel_q;
   logic       wake_en_q, cyc_wake_q, wd_en_q, wake_q;
   logic [1:0] wd_sel_q;
   logic [3:0] wd_per_q;
   logic [1:0] uv_q;
   logic [15:0] rst_cnt_q;
   logic [15:0] sil_cnt_q;
   logic       silent_q;
   logic       mode_wr, wake_evt;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   // rides on a serial frame of any legal size; this port is the decoded word
   assign mode_wr = req.wr && (req.addr == sbcmc_pkg::ADDR_MODE);

   // two-stage synchronisers for pin levels
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         bat_s1_q <= 1'b0; bat_q <= 1'b0;
         ot_s1_q  <= 1'b0; ot_q  <= 1'b0;
         bus_s1_q <= 1'b0; bus_q <= 1'b0;
         rln_s1_q <= 1'b0; rln_q <= 1'b0;
         boot_s1_q <= 1'b0; boot_q <= 1'b0;
      end else begin
         bat_s1_q <= BAT_OK;     bat_q <= bat_s1_q;
         ot_s1_q  <= OVERTEMP;   ot_q  <= ot_s1_q;
         bus_s1_q <= BUS_ACTIVE; bus_q <= bus_s1_q;
         rln_s1_q <= RESET_LINE_N_IN; rln_q <= rln_s1_q;
         boot_s1_q <= FORCED_ACTIVE_BOOT_BIT; boot_q <= boot_s1_q;
      end
   end

   // operating mode state machine
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_q <= sbcmc_pkg::MODE_OFF;
      end else if (!bat_q) begin
         mode_q <= sbcmc_pkg::MODE_OFF;
      end else if (ot_q && mode_q != sbcmc_pkg::MODE_OFF) begin
         mode_q <= sbcmc_pkg::MODE_OVERTEMP;
      end else begin
         case (mode_q)
            sbcmc_pkg::MODE_OFF:
               mode_q <= sbcmc_pkg::MODE_RESET;
            sbcmc_pkg::MODE_OVERTEMP:
               mode_q <= sbcmc_pkg::MODE_RESET;
            sbcmc_pkg::MODE_RESET: begin
               if (rst_cnt_q == 16'(sbcmc_pkg::RESET_HOLD_CYC) && rln_q) begin
                  if (boot_q)
                     mode_q <= sbcmc_pkg::MODE_FORCED;
                  else
                     mode_q <= sbcmc_pkg::MODE_STANDBY;
               end
            end
            sbcmc_pkg::MODE_STANDBY: begin
               if (mode_wr && req.wdata[2:0] == sbcmc_pkg::MSEL_NORMAL)
                  mode_q <= sbcmc_pkg::MODE_NORMAL;
            end
            sbcmc_pkg::MODE_NORMAL: begin
               if (mode_wr && req.wdata[2:0] == sbcmc_pkg::MSEL_STANDBY)
                  mode_q <= sbcmc_pkg::MODE_STANDBY;
            end
            sbcmc_pkg::MODE_FORCED: mode_q <= sbcmc_pkg::MODE_FORCED;
            default: mode_q <= sbcmc_pkg::MODE_OFF;
         endcase
      end
   end

   // reset hold counter, runs only in reset mode
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         rst_cnt_q <= 16'h0000;
      else if (mode_q != sbcmc_pkg::MODE_RESET)
         rst_cnt_q <= 16'h0000;
      else if (rst_cnt_q != 16'(sbcmc_pkg::RESET_HOLD_CYC))
         rst_cnt_q <= rst_cnt_q + 16'h0001;
   end

   // bus silence timer for autonomous biasing
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sil_cnt_q <= 16'h0000;
         silent_q  <= 1'b1;
      end else if (bus_q) begin
         sil_cnt_q <= 16'h0000;
         silent_q  <= 1'b0;
      end else if (sil_cnt_q != 16'(sbcmc_pkg::SILENCE_CYC)) begin
         sil_cnt_q <= sil_cnt_q + 16'h0001;
      end else begin
         silent_q  <= 1'b1;
      end
   end

   // wake events: bus wake in standby, overtemp diagnostic
   assign wake_evt = (wake_en_q && bus_q &&
                      mode_q == sbcmc_pkg::MODE_STANDBY)
                   || ot_q;

   // software registers; wake capture set beats clear
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         msel_q     <= sbcmc_pkg::MSEL_STANDBY;
         wake_en_q  <= 1'b1;
         cyc_wake_q <= 1'b0;
         wd_en_q    <= 1'b0;
         wd_sel_q   <= sbcmc_pkg::WD_TIMEOUT;
         wd_per_q   <= 4'h0;
         uv_q       <= 2'h0;
         wake_q     <= 1'b0;
      end else begin
         if (mode_wr && (req.wdata[2:0] == sbcmc_pkg::MSEL_STANDBY ||
                         req.wdata[2:0] == sbcmc_pkg::MSEL_NORMAL))
            msel_q <= req.wdata[2:0];
         if (req.wr && req.addr == sbcmc_pkg::ADDR_WDOG &&
             SERIAL_EN) begin
            wd_en_q  <= req.wdata[0];
            wd_sel_q <= req.wdata[2:1];
            if (req.wdata[7:4] <= 4'(sbcmc_pkg::WD_CODE_MAX))
               wd_per_q <= req.wdata[7:4];
         end
         // wake re-enable beats a software clear in the same cycle
         if (wake_evt)
            wd_en_q <= 1'b1;
         if (req.wr && req.addr == sbcmc_pkg::ADDR_CFG && SERIAL_EN) begin
            wake_en_q  <= req.wdata[0];
            cyc_wake_q <= req.wdata[1];
            uv_q       <= req.wdata[3:2];
         end
         if (wake_evt ||
             (cyc_wake_q && WDOG_MODE == sbcmc_pkg::WD_TIMEOUT &&
              wd_per_q == 4'h0 && mode_q == sbcmc_pkg::MODE_STANDBY))
            wake_q <= 1'b1;
         else if (req.wr && req.addr == sbcmc_pkg::ADDR_STATUS &&
                  req.wdata[0])
            wake_q <= 1'b0;
      end
   end

   // mode-dependent and register-driven outputs, all registered
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         RESET_LINE_N_OUT    <= 1'b0;
         RESET_LINE_N_OE     <= 1'b1;
         REGULATOR_OUTPUT_EN <= 1'b0;
         SERIAL_EN           <= 1'b0;
         CAN_ACTIVE          <= 1'b0;
         BIAS_MID            <= 1'b0;
         RXD_LOW             <= 1'b0;
         WDOG_MODE           <= sbcmc_pkg::WD_OFF;
         WDOG_PERIOD         <= 4'h0;
         UV_THRESHOLD        <= 2'h0;
      end else begin
         RESET_LINE_N_OUT    <= 1'b0;
         RESET_LINE_N_OE     <= (mode_q == sbcmc_pkg::MODE_RESET &&
                                 rst_cnt_q != 16'(sbcmc_pkg::RESET_HOLD_CYC))
                              || mode_q == sbcmc_pkg::MODE_OFF
                              || mode_q == sbcmc_pkg::MODE_OVERTEMP;
         REGULATOR_OUTPUT_EN <= mode_q != sbcmc_pkg::MODE_OFF &&
                                mode_q != sbcmc_pkg::MODE_OVERTEMP;
         SERIAL_EN           <= mode_q == sbcmc_pkg::MODE_STANDBY ||
                                mode_q == sbcmc_pkg::MODE_NORMAL ||
                                mode_q == sbcmc_pkg::MODE_FORCED;
         CAN_ACTIVE          <= mode_q == sbcmc_pkg::MODE_NORMAL ||
                                mode_q == sbcmc_pkg::MODE_FORCED;
         BIAS_MID            <= wake_en_q && !silent_q &&
                                mode_q == sbcmc_pkg::MODE_STANDBY;
         RXD_LOW             <= wake_q;
         if (mode_q == sbcmc_pkg::MODE_NORMAL && wd_en_q)
            WDOG_MODE <= wd_sel_q;
         else if (mode_q == sbcmc_pkg::MODE_STANDBY && wd_en_q)
            WDOG_MODE <= sbcmc_pkg::WD_TIMEOUT;
         else
            WDOG_MODE <= sbcmc_pkg::WD_OFF;
         WDOG_PERIOD         <= wd_per_q;
         UV_THRESHOLD        <= uv_q;
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B)
         RDATA <= 8'h00;
      else if (req.rd) begin
         case (req.addr)
            sbcmc_pkg::ADDR_MODE:   RDATA <= {5'h00, msel_q};
            sbcmc_pkg::ADDR_STATUS: RDATA <= {4'h0, 1'(mode_q), 2'h0,
                                              wake_q};
            sbcmc_pkg::ADDR_WDOG:   RDATA <= {wd_per_q, 1'b0, wd_sel_q,
                                              wd_en_q};
            sbcmc_pkg::ADDR_CFG:    RDATA <= {4'h0, uv_q, cyc_wake_q,
                                              wake_en_q};
            default:                RDATA <= 8'h00;
         endcase
      end else
         RDATA <= 8'h00;
   end

   // assertions
   property p_std_to_norm;
      @(posedge MCLK) disable iff (!RST_B)
      (mode_q == sbcmc_pkg::MODE_STANDBY && mode_wr &&
       req.wdata[2:0] == sbcmc_pkg::MSEL_NORMAL && bat_q && !ot_q)
      |=> mode_q == sbcmc_pkg::MODE_NORMAL;
   endproperty
   a_std_to_norm: assert property (p_std_to_norm)
      else $error("standby did not enter normal");

   property p_norm_to_std;
      @(posedge MCLK) disable iff (!RST_B)
      (mode_q == sbcmc_pkg::MODE_NORMAL && mode_wr &&
       req.wdata[2:0] == sbcmc_pkg::MSEL_STANDBY && bat_q && !ot_q)
      |=> mode_q == sbcmc_pkg::MODE_STANDBY;
   endproperty
   a_norm_to_std: assert property (p_norm_to_std)
      else $error("normal did not enter standby");

   property p_bad_code;
      @(posedge MCLK) disable iff (!RST_B)
      (mode_q == sbcmc_pkg::MODE_NORMAL && mode_wr &&
       req.wdata[2:0] != sbcmc_pkg::MSEL_STANDBY && bat_q && !ot_q)
      |=> mode_q == sbcmc_pkg::MODE_NORMAL;
   endproperty
   a_bad_code: assert property (p_bad_code)
      else $error("illegal mode code changed mode");

   property p_std_can_off;
      @(posedge MCLK) disable iff (!RST_B)
      mode_q == sbcmc_pkg::MODE_STANDBY |=> !CAN_ACTIVE && SERIAL_EN;
   endproperty
   a_std_can_off: assert property (p_std_can_off)
      else $error("transceiver active in standby");

   property p_reset_low;
      @(posedge MCLK) disable iff (!RST_B)
      $rose(mode_q == sbcmc_pkg::MODE_RESET)
      |=> RESET_LINE_N_OE && !SERIAL_EN && WDOG_MODE == sbcmc_pkg::WD_OFF;
   endproperty
   a_reset_low: assert property (p_reset_low)
      else $error("reset mode not holding line");

   property p_wake_rxd;
      @(posedge MCLK) disable iff (!RST_B)
      wake_evt |=> ##1 RXD_LOW;
   endproperty
   a_wake_rxd: assert property (p_wake_rxd)
      else $error("wake not shown on receive pin");

   property p_wd_reen;
      @(posedge MCLK) disable iff (!RST_B)
      wake_evt |=> wd_en_q;
   endproperty
   a_wd_reen: assert property (p_wd_reen)
      else $error("watchdog not re-enabled by wake");

   property p_off_path;
      @(posedge MCLK) disable iff (!RST_B)
      (mode_q == sbcmc_pkg::MODE_OFF && bat_q && !ot_q)
      |=> mode_q == sbcmc_pkg::MODE_RESET;
   endproperty
   a_off_path: assert property (p_off_path)
      else $error("off did not pass to reset");

   c_norm: cover property (@(posedge MCLK) mode_q ==
                           sbcmc_pkg::MODE_NORMAL);
   c_wake: cover property (@(posedge MCLK) $rose(RXD_LOW));
   c_bias: cover property (@(posedge MCLK) $rose(BIAS_MID));
endmodule
`default_nettype wire

/* verif/sbc_operating_mode_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sbc_operating_mode_controller_tb;
   logic       mclk     = 1'b0;
   logic       rst_b    = 1'b0;
   logic       bat_ok   = 1'b0;
   logic       overtemp = 1'b0;
   logic       boot_bit = 1'b0;
   logic [7:0] addr     = 8'h00;
   logic [7:0] wdata    = 8'h00;
   logic       wr       = 1'b0;
   logic       rd       = 1'b0;
   logic       hold_low = 1'b0;
   logic       bus_on   = 1'b0;
   logic       line_in, bus_act, line_oe, reg_en, ser_en, can_act;
   logic       bias_mid, rxd_low, line_out;
   logic [7:0] rdata, d;
   logic [1:0] wd_mode, uv_thr;
   logic [3:0] wd_per;
   int         fails       = 0;
   int         checks_done = 0;

   // 50 MHz clock
   always #10 mclk = ~mclk;

   sbcmc_host_model sbcmc_host_model_i (.reset_oe(line_oe),
      .hold_low(hold_low), .bus_on(bus_on), .reset_in(line_in),
      .bus_active(bus_act));

   sbcmc_top sbcmc_top_i (.MCLK(mclk), .RST_B(rst_b), .BAT_OK(bat_ok),
      .OVERTEMP(overtemp), .BUS_ACTIVE(bus_act), .RESET_LINE_N_IN(line_in),
      .FORCED_ACTIVE_BOOT_BIT(boot_bit), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .RESET_LINE_N_OUT(line_out),
      .RESET_LINE_N_OE(line_oe), .REGULATOR_OUTPUT_EN(reg_en),
      .SERIAL_EN(ser_en), .CAN_ACTIVE(can_act), .BIAS_MID(bias_mid),
      .RXD_LOW(rxd_low), .WDOG_MODE(wd_mode), .WDOG_PERIOD(wd_per),
      .UV_THRESHOLD(uv_thr));

   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // wait n edges, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   // bounded wait: 0 serial enable, 1 wake pin, 2 bias
   task automatic wait_bit(input int sel, input logic lvl, input int lim);
      logic b;
      for (int i = 0; i < lim; i++) begin
         cyc(1);
         b = (sel == 0) ? ser_en : (sel == 1) ? rxd_low : bias_mid;
         if (b === lvl) break;
      end
      chk(b, lvl);
   endtask

   // power-up through reset, host stretches the reset pulse
   task automatic t_boot;
      @(posedge mclk);
      bat_ok   <= 1'b1;
      hold_low <= 1'b1;
      cyc(20);
      chk(line_oe, 1'b1);
      chk(line_out, 1'b0);
      chk(ser_en, 1'b0);
      chk(wd_mode, sbcmc_pkg::WD_OFF);
      cyc(1100);
      chk(ser_en, 1'b0);
      @(posedge mclk);
      hold_low <= 1'b0;
      wait_bit(0, 1'b1, 50);
      chk(line_oe, 1'b0);
      chk(reg_en, 1'b1);
      chk(can_act, 1'b0);
      rd_reg(sbcmc_pkg::ADDR_CFG, d);
      chk(d[0], 1'b1);
      rd_reg(8'h55, d);
      chk(d, 8'h00);
      $display("test boot finished");
   endtask

   // mode commands, legal and ignored codes
   task automatic t_modes;
      for (int c = 0; c < 7; c++) wr_reg(sbcmc_pkg::ADDR_MODE, 8'(c));
      cyc(3);
      chk(can_act, 1'b0);
      wr_reg(sbcmc_pkg::ADDR_MODE, 8'h07);
      cyc(2);
      chk(can_act, 1'b1);
      chk(reg_en, 1'b1);
      for (int c = 0; c < 7; c++) if (c != 4) wr_reg(8'h01, 8'(c));
      cyc(3);
      chk(can_act, 1'b1);
      rd_reg(sbcmc_pkg::ADDR_MODE, d);
      chk(d, 8'h07);
      wr_reg(sbcmc_pkg::ADDR_MODE, 8'h04);
      cyc(2);
      chk(can_act, 1'b0);
      chk(ser_en, 1'b1);
      rd_reg(sbcmc_pkg::ADDR_MODE, d);
      chk(d, 8'h04);
      $display("test modes finished");
   endtask

   // watchdog mode and period per operating mode
   task automatic t_wdog;
      wr_reg(sbcmc_pkg::ADDR_MODE, 8'h07);
      wr_reg(sbcmc_pkg::ADDR_WDOG, 8'h93);
      cyc(2);
      chk(wd_mode, sbcmc_pkg::WD_WINDOW);
      chk(wd_per, 4'h9);
      wr_reg(sbcmc_pkg::ADDR_WDOG, 8'hA5);
      cyc(2);
      chk(wd_per, 4'h9);
      wr_reg(sbcmc_pkg::ADDR_WDOG, 8'h05);
      cyc(2);
      chk(wd_mode, sbcmc_pkg::WD_TIMEOUT);
      chk(wd_per, 4'h0);
      wr_reg(sbcmc_pkg::ADDR_MODE, 8'h04);
      wr_reg(sbcmc_pkg::ADDR_WDOG, 8'h03);
      cyc(3);
      chk(wd_mode, sbcmc_pkg::WD_TIMEOUT);
      wr_reg(sbcmc_pkg::ADDR_WDOG, 8'h02);
      cyc(2);
      chk(wd_mode, sbcmc_pkg::WD_OFF);
      for (int u = 0; u < 4; u++) begin
         wr_reg(sbcmc_pkg::ADDR_CFG, 8'((u << 2) | 1));
         cyc(2);
         chk(uv_thr, 8'(u));
      end
      $display("test watchdog finished");
   endtask

   // bus wake, biasing, wake flag clearing
   task automatic t_wake;
      wr_reg(sbcmc_pkg::ADDR_STATUS, 8'h01);
      cyc(2);
      chk(rxd_low, 1'b0);
      @(posedge mclk);
      bus_on <= 1'b1;
      wait_bit(1, 1'b1, 200);
      wait_bit(2, 1'b1, 200);
      chk(wd_mode, sbcmc_pkg::WD_TIMEOUT);
      rd_reg(sbcmc_pkg::ADDR_STATUS, d);
      chk(d[0], 1'b1);
      @(posedge mclk);
      bus_on <= 1'b0;
      cyc(2000);
      chk(bias_mid, 1'b1);
      wait_bit(2, 1'b0, 700);
      wr_reg(sbcmc_pkg::ADDR_STATUS, 8'h01);
      wr_reg(sbcmc_pkg::ADDR_CFG, 8'h00);
      cyc(2);
      chk(rxd_low, 1'b0);
      @(posedge mclk);
      bus_on <= 1'b1;
      cyc(200);
      chk(rxd_low, 1'b0);
      @(posedge mclk);
      bus_on <= 1'b0;
      $display("test wake finished");
   endtask

   // overheating and recovery through reset
   task automatic t_hot;
      @(posedge mclk);
      overtemp <= 1'b1;
      cyc(10);
      chk(line_oe, 1'b1);
      chk(ser_en, 1'b0);
      @(posedge mclk);
      overtemp <= 1'b0;
      cyc(10);
      chk(ser_en, 1'b0);
      chk(wd_mode, sbcmc_pkg::WD_OFF);
      wait_bit(0, 1'b1, 1100);
      chk(rxd_low, 1'b1);
      $display("test overtemp finished");
   endtask

   // cyclic wake in standby with timeout watchdog, period code 0
   task automatic t_cyclic;
      wr_reg(sbcmc_pkg::ADDR_STATUS, 8'h01);
      cyc(2);
      chk(rxd_low, 1'b0);
      chk(wd_mode, sbcmc_pkg::WD_TIMEOUT);
      wr_reg(sbcmc_pkg::ADDR_CFG, 8'h02);
      cyc(3);
      chk(rxd_low, 1'b1);
      wr_reg(sbcmc_pkg::ADDR_CFG, 8'h00);
      wr_reg(sbcmc_pkg::ADDR_STATUS, 8'h01);
      cyc(3);
      chk(rxd_low, 1'b0);
      $display("test cyclic finished");
   endtask

   // strap set: recovery through reset ends in forced normal
   task automatic t_forced;
      @(posedge mclk);
      boot_bit <= 1'b1;
      overtemp <= 1'b1;
      cyc(10);
      chk(ser_en, 1'b0);
      @(posedge mclk);
      overtemp <= 1'b0;
      wait_bit(0, 1'b1, 1100);
      chk(can_act, 1'b1);
      chk(wd_mode, sbcmc_pkg::WD_OFF);
      chk(reg_en, 1'b1);
      $display("test forced finished");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      t_boot();
      t_modes();
      t_wdog();
      t_wake();
      t_cyclic();
      t_hot();
      t_forced();
      tally_and_finish();
   end

   // hang guard, well beyond the expected run
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* verif/sbcmc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sbcmc_host_model (
   input  wire logic reset_oe,
   input  wire logic hold_low,
   input  wire logic bus_on,
   output logic      reset_in,
   output logic      bus_active
);
   logic link_clk = 1'b0;

   // link clock, 160 ns period, still while the bus is quiet
   always begin
      #80;
      link_clk = bus_on ? ~link_clk : 1'b0;
   end

   // open drain reset wire with pull-up; host may also hold it low
   assign reset_in = ~(reset_oe | hold_low);

   // bus traffic pattern, recessive when silent
   assign bus_active = bus_on & link_clk;
endmodule
`default_nettype wire
